/* gpp_pkg.sv */
// Constants, types and register map of the GPIO port block
`default_nettype none
package gpp_pkg;
  localparam int NPIN = 26;
  localparam int FW = 4;
  localparam int FPR = 8;
  localparam logic [7:0] OFS_DATA = 8'h00;
  localparam logic [7:0] OFS_DIR = 8'h04;
  localparam logic [7:0] OFS_PE = 8'h08;
  localparam logic [7:0] OFS_DS = 8'h0c;
  localparam logic [7:0] OFS_IS = 8'h10;
  localparam logic [7:0] OFS_IBE = 8'h14;
  localparam logic [7:0] OFS_IEV = 8'h18;
  localparam logic [7:0] OFS_IE = 8'h1c;
  localparam logic [7:0] OFS_RIS = 8'h20;
  localparam logic [7:0] OFS_MIS = 8'h24;
  localparam logic [7:0] OFS_IC = 8'h28;
  localparam logic [7:0] OFS_FSA = 8'h2c;
  localparam logic [7:0] OFS_FSB = 8'h30;
  localparam logic [7:0] OFS_FSC = 8'h34;
  localparam logic [7:0] OFS_FSD = 8'h38;
  localparam logic [7:0] OFS_SET = 8'h3c;
  localparam logic [7:0] OFS_CLR = 8'h40;
  localparam logic [7:0] OFS_CAP = 8'h44;
  localparam logic [25:0] RST_ZERO = 26'h000_0000;
  localparam logic [25:0] RST_PE = 26'h3ff_ffff;
  localparam logic [31:0] RST_FSA = 32'h0000_0000;
  localparam logic [31:0] RST_FSB = 32'h0000_0110;
  localparam logic [31:0] RST_FSC = 32'h0000_0000;
  localparam logic [31:0] RST_FSD = 32'h0000_0000;
  localparam logic [31:0] RST_CAP = 32'h0000_0000;
  localparam int CAP_A_LSB = 0;
  localparam int CAP_B_LSB = 8;
  localparam int CAP_W = 5;
  typedef enum logic [2:0] {
    GPP_FN_GPIO = 3'h0,
    GPP_FN_SER1 = 3'h1,
    GPP_FN_SER0 = 3'h4,
    GPP_FN_SER2 = 3'h5
  } gpp_fn_t;
  typedef struct packed {
    logic [25:0] dout;
    logic [25:0] oe;
  } gpp_alt_t;
  typedef struct packed {
    logic [25:0] dout;
    logic [25:0] oe_n;
    logic [25:0] pull_en;
    logic [25:0] drive_hi;
  } gpp_pad_t;
endpackage
`default_nettype wire

/* gpp_port.sv */
// GPIO port: APB registers, pad control, function select, pin event detection
`default_nettype none
module gpp_port (
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic [25:0] pin_in,
  output var gpp_pkg::gpp_pad_t pad_out,
  input wire gpp_pkg::gpp_alt_t ser_zero_in,
  input wire gpp_pkg::gpp_alt_t ser_one_in,
  input wire gpp_pkg::gpp_alt_t ser_two_in,
  output logic [25:0] pin_sync_out,
  output logic [1:0] timer_capture_out
);
  logic [25:0] pin_m, pin_s, pin_q;
  logic [25:0] dout, dir, pe, ds, is_r, irq_both_edge_select, irq_polarity_select, ie, raw_irq_status, masked_irq_status;
  logic [2:0] fsel [26];
  logic [31:0] cap;
  logic [3:0][31:0] mrd;
  logic [25:0] drv_en, drv_val, rise, fall, edge_hit, lvl_hit, hit;
  logic [31:0] next_rd;
  logic setup, wr, mapped;
  logic [25:0] wd;
  logic [25:0] is_gpio;
  logic [4:0] cap_a_idx, cap_b_idx;
  logic cap_a_ok, cap_b_ok;

  assign setup = psel_in & ~penable_in;
  assign wr = psel_in & penable_in & pwrite_in;
  assign wd = pwdata_in[25:0];
  assign pready_out = 1'b1;
  assign pslverr_out = psel_in & penable_in & ~mapped;

  // First stage is read only by the second
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pin_m <= gpp_pkg::RST_ZERO;
      pin_s <= gpp_pkg::RST_ZERO;
      pin_q <= gpp_pkg::RST_ZERO;
    end else begin
      pin_m <= pin_in;
      pin_s <= pin_m;
      pin_q <= pin_s;
    end
  end
  assign pin_sync_out = pin_s;

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      dout <= gpp_pkg::RST_ZERO;
    end else if (wr && paddr_in == gpp_pkg::OFS_DATA) begin
      dout <= wd;
    end else if (wr && paddr_in == gpp_pkg::OFS_SET) begin
      dout <= dout | wd;
    end else if (wr && paddr_in == gpp_pkg::OFS_CLR) begin
      dout <= dout & ~wd;
    end
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      dir <= gpp_pkg::RST_ZERO;
      pe <= gpp_pkg::RST_PE;
      ds <= gpp_pkg::RST_ZERO;
    end else if (wr) begin
      if (paddr_in == gpp_pkg::OFS_DIR) begin
        dir <= wd;
      end
      if (paddr_in == gpp_pkg::OFS_PE) begin
        pe <= wd;
      end
      if (paddr_in == gpp_pkg::OFS_DS) begin
        ds <= wd;
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      is_r <= gpp_pkg::RST_ZERO;
      irq_both_edge_select <= gpp_pkg::RST_ZERO;
      irq_polarity_select <= gpp_pkg::RST_ZERO;
      ie <= gpp_pkg::RST_ZERO;
    end else if (wr) begin
      if (paddr_in == gpp_pkg::OFS_IS) begin
        is_r <= wd;
      end
      if (paddr_in == gpp_pkg::OFS_IBE) begin
        irq_both_edge_select <= wd;
      end
      if (paddr_in == gpp_pkg::OFS_IEV) begin
        irq_polarity_select <= wd;
      end
      if (paddr_in == gpp_pkg::OFS_IE) begin
        ie <= wd;
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cap <= gpp_pkg::RST_CAP;
    end else if (wr && paddr_in == gpp_pkg::OFS_CAP) begin
      cap <= {19'h0_0000, pwdata_in[12:8], 3'h0, pwdata_in[4:0]};
    end
  end

  assign cap_a_idx = cap[gpp_pkg::CAP_A_LSB+:gpp_pkg::CAP_W];
  assign cap_b_idx = cap[gpp_pkg::CAP_B_LSB+:gpp_pkg::CAP_W];
  assign cap_a_ok = cap_a_idx < 5'(gpp_pkg::NPIN);
  assign cap_b_ok = cap_b_idx < 5'(gpp_pkg::NPIN);

  // Out-of-range capture selections give a steady low, never an unknown
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      timer_capture_out <= 2'h0;
    end else begin
      timer_capture_out[0] <= cap_a_ok ? pin_s[cap_a_idx] : 1'b0;
      timer_capture_out[1] <= cap_b_ok ? pin_s[cap_b_idx] : 1'b0;
    end
  end

  // Edge detection compares against the previous synchronised level
  assign rise = pin_s & ~pin_q;
  assign fall = ~pin_s & pin_q;
  assign edge_hit = (irq_both_edge_select & (rise | fall)) | (~irq_both_edge_select & ((irq_polarity_select & rise) | (~irq_polarity_select & fall)));
  assign lvl_hit = ~(irq_polarity_select ^ pin_s);
  assign hit = (is_r & lvl_hit) | (~is_r & edge_hit);

  // A new event in the clearing cycle keeps its bit set
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      raw_irq_status <= gpp_pkg::RST_ZERO;
    end else if (wr && paddr_in == gpp_pkg::OFS_IC) begin
      raw_irq_status <= (raw_irq_status & ~wd) | hit;
    end else begin
      raw_irq_status <= raw_irq_status | hit;
    end
  end
  assign masked_irq_status = ie & raw_irq_status;

  genvar gi;
  generate
    for (gi = 0; gi < gpp_pkg::NPIN; gi++) begin : g_pin
      localparam int RG = gi / gpp_pkg::FPR;
      localparam int LSB = (gi % gpp_pkg::FPR) * gpp_pkg::FW;
      localparam logic [7:0] OFS = gpp_pkg::OFS_FSA + 8'(RG * 4);
      localparam logic [31:0] RV = (RG == 0) ? gpp_pkg::RST_FSA :
                                   (RG == 1) ? gpp_pkg::RST_FSB :
                                   (RG == 2) ? gpp_pkg::RST_FSC : gpp_pkg::RST_FSD;
      always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
          fsel[gi] <= RV[LSB+:3];
        end else if (wr && paddr_in == OFS) begin
          fsel[gi] <= pwdata_in[LSB+:3];
        end
      end
      // Reserved codes leave the pin undriven
      always_comb begin
        drv_en[gi] = 1'b0;
        drv_val[gi] = 1'b0;
        case (fsel[gi])
          gpp_pkg::GPP_FN_GPIO: begin
            drv_en[gi] = dir[gi];
            drv_val[gi] = dout[gi];
          end
          gpp_pkg::GPP_FN_SER1: begin
            drv_en[gi] = ser_one_in.oe[gi];
            drv_val[gi] = ser_one_in.dout[gi];
          end
          gpp_pkg::GPP_FN_SER0: begin
            drv_en[gi] = ser_zero_in.oe[gi];
            drv_val[gi] = ser_zero_in.dout[gi];
          end
          gpp_pkg::GPP_FN_SER2: begin
            drv_en[gi] = ser_two_in.oe[gi];
            drv_val[gi] = ser_two_in.dout[gi];
          end
          default: begin
            drv_en[gi] = 1'b0;
          end
        endcase
      end
    end
  endgenerate

  always_comb begin
    mrd = '0;
    is_gpio = '0;
    for (int i = 0; i < gpp_pkg::NPIN; i++) begin
      is_gpio[i] = (fsel[i] == gpp_pkg::GPP_FN_GPIO);
      mrd[i/gpp_pkg::FPR][(i%gpp_pkg::FPR)*gpp_pkg::FW+:3] = fsel[i];
    end
  end

  // Pad controls are registered so the pins never see decode glitches
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pad_out.dout <= gpp_pkg::RST_ZERO;
      pad_out.oe_n <= ~gpp_pkg::RST_ZERO;
      pad_out.pull_en <= gpp_pkg::RST_PE;
      pad_out.drive_hi <= gpp_pkg::RST_ZERO;
    end else begin
      pad_out.dout <= drv_val;
      pad_out.oe_n <= ~drv_en;
      pad_out.pull_en <= pe;
      pad_out.drive_hi <= ds;
    end
  end

  always_comb begin
    next_rd = 32'h0000_0000;
    mapped = 1'b1;
    case (paddr_in)
      gpp_pkg::OFS_DATA: next_rd[25:0] = pin_s;
      gpp_pkg::OFS_DIR: next_rd[25:0] = dir;
      gpp_pkg::OFS_PE: next_rd[25:0] = pe;
      gpp_pkg::OFS_DS: next_rd[25:0] = ds;
      gpp_pkg::OFS_IS: next_rd[25:0] = is_r;
      gpp_pkg::OFS_IBE: next_rd[25:0] = irq_both_edge_select;
      gpp_pkg::OFS_IEV: next_rd[25:0] = irq_polarity_select;
      gpp_pkg::OFS_IE: next_rd[25:0] = ie;
      gpp_pkg::OFS_RIS: next_rd[25:0] = raw_irq_status;
      gpp_pkg::OFS_MIS: next_rd[25:0] = masked_irq_status;
      gpp_pkg::OFS_FSA: next_rd = mrd[0];
      gpp_pkg::OFS_FSB: next_rd = mrd[1];
      gpp_pkg::OFS_FSC: next_rd = mrd[2];
      gpp_pkg::OFS_FSD: next_rd = mrd[3];
      gpp_pkg::OFS_CAP: next_rd = cap;
      gpp_pkg::OFS_IC, gpp_pkg::OFS_SET, gpp_pkg::OFS_CLR: next_rd = 32'h0000_0000;
      default: mapped = 1'b0;
    endcase
  end

  // Read data is captured in the setup cycle and held through access
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      prdata_out <= 32'h0000_0000;
    end else if (setup && !pwrite_in) begin
      prdata_out <= next_rd;
    end
  end

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);

  chk_gpio_drive: assert property (
    $past(nrst_in) |->
      ((pad_out.oe_n | (pad_out.dout ^ $past(dout))) & $past(is_gpio & dir)) == 26'h000_0000
  ) else $error("gpio output pin not driven with stored value");
  chk_data_write: assert property (
    wr && paddr_in == gpp_pkg::OFS_DATA |=> dout == $past(wd)
  ) else $error("value register write not stored");
  chk_dout_hold: assert property (
    !(wr && (paddr_in == gpp_pkg::OFS_DATA || paddr_in == gpp_pkg::OFS_SET ||
      paddr_in == gpp_pkg::OFS_CLR)) |=> dout == $past(dout)
  ) else $error("output value changed without a write");
  chk_dir_write: assert property (
    wr && paddr_in == gpp_pkg::OFS_DIR |=> dir == $past(wd)
  ) else $error("direction write not stored");
  chk_pe_write: assert property (
    wr && paddr_in == gpp_pkg::OFS_PE |=> pe == $past(wd)
  ) else $error("pull enable write not stored");
  chk_ds_write: assert property (
    wr && paddr_in == gpp_pkg::OFS_DS |=> ds == $past(wd)
  ) else $error("drive strength write not stored");
  chk_sense_write: assert property (
    wr && paddr_in == gpp_pkg::OFS_IS |=> is_r == $past(wd)
  ) else $error("sense write not stored");
  chk_edge_write: assert property (
    wr && paddr_in == gpp_pkg::OFS_IBE |=> irq_both_edge_select == $past(wd)
  ) else $error("both-edge write not stored");
  chk_pol_write: assert property (
    wr && paddr_in == gpp_pkg::OFS_IEV |=> irq_polarity_select == $past(wd)
  ) else $error("polarity write not stored");
  chk_mask_write: assert property (
    wr && paddr_in == gpp_pkg::OFS_IE |=> ie == $past(wd)
  ) else $error("enable write not stored");
  chk_pull_mirror: assert property (
    $past(nrst_in) |-> pad_out.pull_en == $past(pe)
  ) else $error("pad pull does not follow register");
  chk_drive_mirror: assert property (
    $past(nrst_in) |-> pad_out.drive_hi == $past(ds)
  ) else $error("pad drive does not follow register");
  chk_sync_chain: assert property (
    $past(nrst_in, 2) |-> pin_s == $past(pin_in, 2)
  ) else $error("pin level not two flops behind");
  chk_ser_one: assert property (
    $past(nrst_in) && $past(fsel[9] == gpp_pkg::GPP_FN_SER1) |->
      pad_out.oe_n[9] == $past(~ser_one_in.oe[9])
  ) else $error("serial one does not own its pin");
  chk_ser_zero: assert property (
    $past(nrst_in) && $past(fsel[9] == gpp_pkg::GPP_FN_SER0) |->
      pad_out.oe_n[9] == $past(~ser_zero_in.oe[9])
  ) else $error("serial zero does not own its pin");
  chk_ser_two: assert property (
    $past(nrst_in) && $past(fsel[9] == gpp_pkg::GPP_FN_SER2) |->
      pad_out.oe_n[9] == $past(~ser_two_in.oe[9])
  ) else $error("serial two does not own its pin");
  chk_fsa_field: assert property (
    wr && paddr_in == gpp_pkg::OFS_FSA |=> fsel[1] == $past(pwdata_in[6:4])
  ) else $error("function field misplaced");
  chk_fsb_field: assert property (
    wr && paddr_in == gpp_pkg::OFS_FSB |=> fsel[9] == $past(pwdata_in[6:4])
  ) else $error("function field misplaced");
  chk_fsc_write: assert property (
    wr && paddr_in == gpp_pkg::OFS_FSC |=> fsel[16] == $past(pwdata_in[2:0])
  ) else $error("third select register write not stored");
  chk_fsd_write: assert property (
    wr && paddr_in == gpp_pkg::OFS_FSD |=> fsel[25] == $past(pwdata_in[6:4])
  ) else $error("fourth select register write not stored");
  chk_fsd_read: assert property (
    setup && !pwrite_in && paddr_in == gpp_pkg::OFS_FSD |=> prdata_out[31:7] == 25'h000_0000
  ) else $error("fourth select register shows unused pins");
  chk_cap_write: assert property (
    wr && paddr_in == gpp_pkg::OFS_CAP |=> cap[4:0] == $past(pwdata_in[4:0])
  ) else $error("capture select write not stored");
  chk_cap_route: assert property (
    $past(nrst_in) && $past(cap[4:0] == 5'h04) |-> timer_capture_out[0] == $past(pin_s[4])
  ) else $error("capture input not routed from selected pin");
  chk_cap_range: assert property (
    $past(nrst_in) && $past(cap[12:8] > 5'h19) |-> timer_capture_out[1] == 1'b0
  ) else $error("out of range capture not low");
  chk_data_read: assert property (
    setup && !pwrite_in && paddr_in == gpp_pkg::OFS_DATA |=> prdata_out[25:0] == $past(pin_in, 3)
  ) else $error("value register read does not show pin level");
  chk_set_bits: assert property (
    wr && paddr_in == gpp_pkg::OFS_SET |=> dout == ($past(dout) | $past(pwdata_in[25:0]))
  ) else $error("set register changed wrong output bits");
  chk_clr_bits: assert property (
    wr && paddr_in == gpp_pkg::OFS_CLR |=> dout == ($past(dout) & ~$past(pwdata_in[25:0]))
  ) else $error("clear register changed wrong output bits");
  chk_rise_single: assert property (
    ##1 (raw_irq_status & $past(~is_r & ~irq_both_edge_select & irq_polarity_select & rise)) == $past(~is_r & ~irq_both_edge_select & irq_polarity_select & rise)
  ) else $error("single rising edge not latched");
  chk_both_edges: assert property (
    ##1 (raw_irq_status & $past(~is_r & irq_both_edge_select & (rise | fall))) == $past(~is_r & irq_both_edge_select & (rise | fall))
  ) else $error("both-edge event not latched");
  chk_level_low: assert property (
    ##1 (raw_irq_status & $past(is_r & ~irq_polarity_select & ~pin_s)) == $past(is_r & ~irq_polarity_select & ~pin_s)
  ) else $error("low level not latched");
  chk_level_high: assert property (
    ##1 (raw_irq_status & $past(is_r & irq_polarity_select & pin_s)) == $past(is_r & irq_polarity_select & pin_s)
  ) else $error("high level not latched");
  chk_fall_single: assert property (
    ##1 (raw_irq_status & $past(~is_r & ~irq_both_edge_select & ~irq_polarity_select & fall)) == $past(~is_r & ~irq_both_edge_select & ~irq_polarity_select & fall)
  ) else $error("single falling edge not latched");
  chk_ic_keep: assert property (
    wr && paddr_in == gpp_pkg::OFS_IC |=> ($past(raw_irq_status) & ~$past(wd) & ~raw_irq_status) == 26'h000_0000
  ) else $error("interrupt clear dropped an unselected bit");
  chk_mis_read: assert property (
    setup && !pwrite_in && paddr_in == gpp_pkg::OFS_MIS |=>
      prdata_out[25:0] == ($past(ie) & $past(raw_irq_status))
  ) else $error("masked status read is not enable AND raw");
  chk_ic_clear: assert property (
    wr && paddr_in == gpp_pkg::OFS_IC |=>
      (raw_irq_status & $past(pwdata_in[25:0]) & ~$past(hit)) == 26'h000_0000
  ) else $error("interrupt clear left raw bit set");
  chk_unmapped_err: assert property (
    psel_in && penable_in && paddr_in == 8'h48 |-> pslverr_out
  ) else $error("unmapped access not flagged");

  cov_edge_event: cover property (~is_r[0] && rise[0] ##1 raw_irq_status[0]);
  cov_ic_write: cover property (wr && paddr_in == gpp_pkg::OFS_IC && raw_irq_status != 26'h000_0000);
  cov_set_write: cover property (wr && paddr_in == gpp_pkg::OFS_SET);
  cov_ser_pin: cover property (fsel[9] == gpp_pkg::GPP_FN_SER1 && ser_one_in.oe[9]);
  cov_mis_read: cover property (setup && !pwrite_in && paddr_in == gpp_pkg::OFS_MIS && masked_irq_status[0]);
endmodule
`default_nettype wire

/* gpp_pin_model.sv */
// Board-side pin model: resolves each pin from the port's pad drive
`default_nettype none
module gpp_pin_model (
  input wire gpp_pkg::gpp_pad_t pad_in,
  input wire logic [25:0] ext_in,
  output logic [25:0] pin_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // Board always drives; the port overrides where its output is enabled
  assign pin_out = (pad_in.dout & ~pad_in.oe_n) | (ext_in & pad_in.oe_n);
endmodule
`default_nettype wire

/* gpp_port_bench.sv */
// Self-checking bench of the GPIO port
`default_nettype none
module gpp_port_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] FSC_V = 32'h0412_5410;
  logic clk_sys_in = 1'h0;
  logic nrst_in = 1'h0;
  logic psel = 1'h0;
  logic pen = 1'h0;
  logic pwr = 1'h0;
  logic [7:0] pad = 8'h00;
  logic [31:0] pwd = 32'h0000_0000;
  logic [31:0] prd, rd, v;
  logic prdy, perr, er;
  logic [25:0] ext = 26'h000_0000;
  logic [25:0] pin, psync, d, s;
  logic [1:0] cap, e;
  logic [2:0] c;
  gpp_pkg::gpp_pad_t pads;
  gpp_pkg::gpp_alt_t sz = '0;
  gpp_pkg::gpp_alt_t so = '0;
  gpp_pkg::gpp_alt_t st = '0;
  int errors = 0;
  int tests_run = 0;
  int cyc = 0;
  always #5 clk_sys_in = ~clk_sys_in;
  gpp_port dut (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(pad), .pwdata_in(pwd),
    .prdata_out(prd), .pready_out(prdy), .pslverr_out(perr), .pin_in(pin),
    .pad_out(pads), .ser_zero_in(sz), .ser_one_in(so), .ser_two_in(st),
    .pin_sync_out(psync), .timer_capture_out(cap));
  gpp_pin_model pins (.pad_in(pads), .ext_in(ext), .pin_out(pin));
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      give_verdict();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk_sys_in);
    psel <= 1'h1;
    pwr <= w;
    pad <= a;
    pwd <= wd;
    @(posedge clk_sys_in);
    pen <= 1'h1;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (prdy !== 1'h1 && n < 50);
    rd = prd;
    er = perr;
    psel <= 1'h0;
    pen <= 1'h0;
  endtask
  // Waits first so pad updates and the two-flop pin sync have settled
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string nm);
    repeat (4) @(posedge clk_sys_in);
    apb(1'h0, a, 32'h0000_0000);
    chk(nm, rd, exp);
  endtask
  // Expected {oe_n, dout} of a pin for a function code
  function automatic logic [1:0] fn_pad(input logic [2:0] code, input int i);
    case (code)
      3'h0: return {1'h0, d[i]};
      3'h1: return {~so.oe[i], so.dout[i]};
      3'h4: return {~sz.oe[i], sz.dout[i]};
      3'h5: return {~st.oe[i], st.dout[i]};
      default: return 2'h2;
    endcase
  endfunction
  initial begin
    void'($urandom(68));
    repeat (5) @(posedge clk_sys_in);
    nrst_in <= 1'h1;
    chk("pad oe_n", pads.oe_n, 32'h03ff_ffff);
    chk("pad pull", pads.pull_en, 32'h03ff_ffff);
    rdchk(gpp_pkg::OFS_DIR, 32'h0000_0000, "dir rst");
    rdchk(gpp_pkg::OFS_PE, 32'h03ff_ffff, "pe rst");
    rdchk(gpp_pkg::OFS_DS, 32'h0000_0000, "ds rst");
    for (int a = 16; a < 32; a += 4) rdchk(a[7:0], 32'h0000_0000, "irq rst");
    rdchk(gpp_pkg::OFS_FSB, 32'h0000_0110, "fsb rst");
    rdchk(gpp_pkg::OFS_FSC, 32'h0000_0000, "fsc rst");
    rdchk(gpp_pkg::OFS_FSD, 32'h0000_0000, "fsd rst");
    rdchk(gpp_pkg::OFS_CAP, 32'h0000_0000, "cap rst");
    $display("test reset done");
    for (int a = 4; a < 32; a += 4) begin
      v = $urandom;
      apb(1'h1, a[7:0], v);
      rdchk(a[7:0], v & 32'h03ff_ffff, "cfg rw");
      if (a == 8) chk("pad pull", pads.pull_en, v[25:0]);
      if (a == 12) chk("pad drive", pads.drive_hi, v[25:0]);
    end
    $display("test config done");
    d = 26'($urandom);
    ext <= 26'($urandom);
    apb(1'h1, gpp_pkg::OFS_DIR, 32'h0000_000f);
    apb(1'h1, gpp_pkg::OFS_DATA, {6'h00, d});
    rdchk(gpp_pkg::OFS_DATA, {6'h00, ext[25:4], d[3:0]}, "pin level");
    chk("gpio dout", pads.dout[3:0], d[3:0]);
    chk("gpio oe_n", pads.oe_n[7:0], 32'h0000_00f0);
    chk("pin sync", psync[25:4], ext[25:4]);
    apb(1'h1, gpp_pkg::OFS_DIR, 32'h03ff_ffff);
    s = 26'($urandom);
    apb(1'h1, gpp_pkg::OFS_SET, {6'h00, s});
    d = d | s;
    rdchk(gpp_pkg::OFS_DATA, {6'h00, (d & ~26'h600) | (ext & 26'h600)}, "set");
    s = 26'($urandom);
    apb(1'h1, gpp_pkg::OFS_CLR, {6'h00, s});
    d = d & ~s;
    rdchk(gpp_pkg::OFS_DATA, {6'h00, (d & ~26'h600) | (ext & 26'h600)}, "clr");
    $display("test output done");
    so <= {26'($urandom), 26'($urandom)};
    sz <= {26'($urandom), 26'($urandom)};
    st <= {26'($urandom), 26'($urandom)};
    apb(1'h1, gpp_pkg::OFS_FSC, FSC_V);
    rdchk(gpp_pkg::OFS_FSC, FSC_V, "fsc rw");
    for (int i = 8; i < 24; i++) begin
      c = (i < 16) ? gpp_pkg::RST_FSB[4*(i-8) +: 3] : FSC_V[4*(i-16) +: 3];
      e = fn_pad(c, i);
      chk("fn oe_n", pads.oe_n[i], e[1]);
      if (e[1] == 1'h0) chk("fn dout", pads.dout[i], e[0]);
    end
    apb(1'h1, gpp_pkg::OFS_FSD, 32'hffff_ffff);
    rdchk(gpp_pkg::OFS_FSD, 32'h0000_0077, "fsd rw");
    $display("test function done");
    apb(1'h1, gpp_pkg::OFS_DIR, 32'h0000_0000);
    apb(1'h1, gpp_pkg::OFS_CAP, 32'h0000_1904);
    for (int k = 0; k < 2; k++) begin
      ext <= 26'($urandom);
      rdchk(gpp_pkg::OFS_CAP, 32'h0000_1904, "cap rw");
      chk("capture", cap, {ext[25], ext[4]});
    end
    apb(1'h1, gpp_pkg::OFS_CAP, 32'h0000_1e1e);
    repeat (4) @(posedge clk_sys_in);
    chk("capture off", cap, 32'h0000_0000);
    $display("test capture done");
    apb(1'h1, gpp_pkg::OFS_IE, 32'h0000_0000);
    apb(1'h1, gpp_pkg::OFS_IS, 32'h0000_0004);
    apb(1'h1, gpp_pkg::OFS_IBE, 32'h0000_0002);
    apb(1'h1, gpp_pkg::OFS_IEV, 32'h0000_0005);
    ext <= 26'h000_0000;
    repeat (4) @(posedge clk_sys_in);
    // Raw status is cleared before any interrupt is enabled
    apb(1'h1, gpp_pkg::OFS_IC, 32'h03ff_ffff);
    rdchk(gpp_pkg::OFS_RIS, 32'h0000_0000, "ris clr");
    ext <= 26'h000_000f;
    rdchk(gpp_pkg::OFS_RIS, 32'h0000_0007, "ris rise");
    apb(1'h1, gpp_pkg::OFS_IE, 32'h0000_0005);
    rdchk(gpp_pkg::OFS_MIS, 32'h0000_0005, "mis");
    apb(1'h1, gpp_pkg::OFS_IC, 32'h0000_0007);
    rdchk(gpp_pkg::OFS_RIS, 32'h0000_0004, "ris level");
    rdchk(gpp_pkg::OFS_MIS, 32'h0000_0004, "mis clr");
    ext <= 26'h000_0000;
    rdchk(gpp_pkg::OFS_RIS, 32'h0000_000e, "ris fall");
    $display("test irq done");
    apb(1'h1, 8'h48, 32'hffff_ffff);
    chk("err wr", er, 32'h0000_0001);
    apb(1'h0, 8'h48, 32'h0000_0000);
    chk("err rd", er, 32'h0000_0001);
    chk("err data", rd, 32'h0000_0000);
    apb(1'h0, gpp_pkg::OFS_DIR, 32'h0000_0000);
    chk("no err", er, 32'h0000_0000);
    $display("test unmapped done");
    give_verdict();
  end
endmodule
`default_nettype wire
